// [rtl/usts_top.sv]
// Universal serial two-wire shifter: shift register, edge counter, start/stop detect, SCL hold
//
// Overview of operation
// - Slave may hold SCL low; master checks SCL really went high.
// - SDA falling while SCL high sets the start flag.
// - SDA pulled low if shift bit 7 or port bit is zero, direction set.
// - After start, SCL held low from its first fall until flag cleared.
// - With external clocking SDA is shifted in on the selected SCL edge, rising or falling.
// - Counter overflow after eight bits holds SCL low until software releases.
// - SDA is delayed before start detection; detector works only in two-wire mode.
// - Start detection also works without the system clock, for wake-up.
// - SCL and serial clock toggle no faster than a quarter of the clock.
// - With external clocking the counter counts both pin edges, or toggle strobes if the clock bit is set.
// - Counter preset to F overflows on next pin edge, an edge interrupt.
// - A software clock strobe can advance the counter into overflow.
// - CPU accesses the shift register directly; a write beats a same-cycle shift.
// - Shift left, clocked by pin edge, timer match or software strobe.
// - With outputs disabled the pin inputs still feed shifter and counter.
// - Bit 7 reaches the pin through a latch, open half-cycle or always.
// - Status holds start, overflow, stop, collision flags and count; resets zero.
// - Outputs off or three-wire, external clock, no strobe: pin edges set start.
// - Start flag clears on written one, releasing SCL hold; gated interrupt request.
// - Overflow flag sets on 15 to 0 wrap, clears on one, releases hold.
// - Stop flag sets on stop condition in two-wire mode, clears on one.
// - In two-wire mode collision reads one when bit 7 differs from the SDA pin level.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module usts_top
    import usts_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    output logic            do_out,
    output logic            do_oe_out,
    input  wire logic       port_sda_in,
    input  wire logic       dir_sda_in,
    input  wire logic       port_scl_in,
    input  wire logic       dir_scl_in,
    input  wire logic       dir_do_in,
    input  wire logic       timer_match_in,
    input  wire logic       global_irq_en_in,
    output logic            start_irq_out,
    output logic            ovf_irq_out,
    output logic            toggle_strobe_out,
    output logic            wake_out
);

    logic            ctrl_wr;
    logic            status_wr;
    logic            data_wr;
    logic            sie_r;
    logic            oie_r;
    usts_wire_mode_t wm_r;
    usts_clk_src_t   cs_r;
    logic            swc_r;
    logic            two_wire;
    logic            clk_strobe;
    logic            tc_strobe;
    logic [2:0]      sda_s_r;
    logic [2:0]      scl_s_r;
    logic            sda_f_r;
    logic            scl_f_r;
    logic            scl_q_r;
    logic            scl_rise;
    logic            scl_fall;
    logic            scl_edge;
    logic [SDA_DLY_CYC-1:0] sda_dly_r;
    logic            sda_dq_r;
    logic            sda_d;
    logic            start_det;
    logic            stop_det;
    logic            start_set;
    logic            shift_en;
    logic            cnt_en;
    logic [7:0]      sr_r;
    logic [3:0]      cnt_r;
    logic [3:0]      cnt_nxt;
    logic            ovf_set;
    logic            start_flag_r;
    logic            ovf_flag_r;
    logic            stop_flag_r;
    logic            start_clr;
    logic            ovf_clr;
    logic            stop_clr;
    logic            start_hold_r;
    logic            ovf_hold;
    logic            collision;
    logic            latch_open;
    logic            out_bit;
    logic            held_bit_r;
    logic            wake_r;
    logic            wake_clr_r;
    logic            wake_rst_n;

    assign ctrl_wr    = wr_in && (addr_in == CTRL_ADDR);
    assign status_wr  = wr_in && (addr_in == STATUS_ADDR);
    assign data_wr    = wr_in && (addr_in == DATA_ADDR);
    assign two_wire   = wm_r[1];
    assign clk_strobe = ctrl_wr && wdata_in[CT_CLK];
    assign tc_strobe  = ctrl_wr && wdata_in[CT_TC];
    assign start_clr  = status_wr && wdata_in[ST_START];
    assign ovf_clr    = status_wr && wdata_in[ST_OVF];
    assign stop_clr   = status_wr && wdata_in[ST_STOP];

    // Control register; the two strobe bits are not stored as strobes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sie_r <= CTRL_RST[CT_SIE];
            oie_r <= CTRL_RST[CT_OIE];
            wm_r  <= WM_OFF;
            cs_r  <= CS_SOFT;
            swc_r <= CTRL_RST[CT_CLK];
        end else if (ctrl_wr) begin
            sie_r <= wdata_in[CT_SIE];
            oie_r <= wdata_in[CT_OIE];
            wm_r  <= usts_wire_mode_t'(wdata_in[CT_WM_LO+1:CT_WM_LO]);
            cs_r  <= usts_clk_src_t'(wdata_in[CT_CS_LO+1:CT_CS_LO]);
            swc_r <= wdata_in[CT_CLK];
        end
    end

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sda_s_r <= 3'h7;
            scl_s_r <= 3'h7;
            sda_f_r <= 1'b1;
            scl_f_r <= 1'b1;
            scl_q_r <= 1'b1;
        end else begin
            sda_s_r <= {sda_s_r[1:0], sda_in};
            scl_s_r <= {scl_s_r[1:0], scl_in};
            scl_q_r <= scl_f_r;
            if (sda_s_r[2] == sda_s_r[1]) begin
                sda_f_r <= sda_s_r[1];
            end
            if (scl_s_r[2] == scl_s_r[1]) begin
                scl_f_r <= scl_s_r[1];
            end
        end
    end

    assign scl_rise = scl_f_r && !scl_q_r;
    assign scl_fall = !scl_f_r && scl_q_r;
    assign scl_edge = scl_rise || scl_fall;

    // Delayed SDA so that SCL is settled when a data edge is judged
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sda_dly_r <= '1;
            sda_dq_r  <= 1'b1;
        end else begin
            sda_dly_r <= {sda_dly_r[SDA_DLY_CYC-2:0], sda_f_r};
            sda_dq_r  <= sda_d;
        end
    end

    assign sda_d     = sda_dly_r[SDA_DLY_CYC-1];
    assign start_det = two_wire && scl_f_r && sda_dq_r && !sda_d;
    assign stop_det  = two_wire && scl_f_r && !sda_dq_r && sda_d;
    assign start_set = start_det ||
                       (!two_wire && cs_r[1] && !swc_r && scl_edge);

    // Clock selection for shifter and counter; inputs act in every wire mode
    always_comb begin
        shift_en = 1'b0;
        cnt_en   = 1'b0;
        unique case (cs_r)
            CS_SOFT: begin
                shift_en = clk_strobe;
                cnt_en   = clk_strobe;
            end
            CS_TIMER: begin
                shift_en = timer_match_in;
                cnt_en   = timer_match_in;
            end
            CS_EXT_RISE: begin
                shift_en = scl_rise;
                cnt_en   = swc_r ? tc_strobe : scl_edge;
            end
            CS_EXT_FALL: begin
                shift_en = scl_fall;
                cnt_en   = swc_r ? tc_strobe : scl_edge;
            end
        endcase
    end

    // Shift register: a CPU write wins over a shift in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sr_r <= DATA_RST;
        end else if (data_wr) begin
            sr_r <= wdata_in;
        end else if (shift_en) begin
            sr_r <= {sr_r[6:0], sda_f_r};
        end
    end

    assign cnt_nxt = cnt_r + CNT_ONE;
    assign ovf_set = cnt_en && !status_wr && (cnt_r == CNT_MAX);

    // Edge counter; a CPU write of the count wins over counting
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= CNT_RST;
        end else if (status_wr) begin
            cnt_r <= wdata_in[3:0];
        end else if (cnt_en) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Sticky flags: a setting event beats a same-cycle clear, except overflow, whose set a status write blocks
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_flag_r <= 1'b0;
        end else if (start_set) begin
            start_flag_r <= 1'b1;
        end else if (start_clr) begin
            start_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovf_flag_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_flag_r <= 1'b1;
        end else if (ovf_clr) begin
            ovf_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_flag_r <= 1'b0;
        end else if (stop_det) begin
            stop_flag_r <= 1'b1;
        end else if (stop_clr) begin
            stop_flag_r <= 1'b0;
        end
    end

    // Start hold engages once the master pulls SCL low after a start
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_hold_r <= 1'b0;
        end else if (!start_flag_r || !two_wire) begin
            start_hold_r <= 1'b0;
        end else if (!scl_f_r) begin
            start_hold_r <= 1'b1;
        end
    end

    assign ovf_hold = two_wire && ovf_flag_r;

    // Output latch in front of the data pin
    assign latch_open = !cs_r[1] || (cs_r[0] ? scl_f_r : !scl_f_r);
    assign out_bit    = latch_open ? sr_r[7] : held_bit_r;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held_bit_r <= 1'b1;
        end else begin
            held_bit_r <= out_bit;
        end
    end

    // Pin drivers: two-wire pins only ever pull low
    assign sda_out    = 1'b0;
    assign sda_oe_out = two_wire && dir_sda_in && (!out_bit || !port_sda_in);
    assign scl_out    = 1'b0;
    assign scl_oe_out = two_wire &&
                        (start_hold_r || ovf_hold || (dir_scl_in && !port_scl_in));
    assign do_out     = out_bit;
    assign do_oe_out  = (wm_r == WM_THREE) && dir_do_in;

    assign collision     = two_wire && (sr_r[7] != sda_f_r);
    assign start_irq_out = start_flag_r && sie_r && global_irq_en_in;
    assign ovf_irq_out   = ovf_flag_r && oie_r && global_irq_en_in;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            toggle_strobe_out <= 1'b0;
        end else begin
            toggle_strobe_out <= tc_strobe;
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                CTRL_ADDR:   rdata_out <= {sie_r, oie_r, wm_r, cs_r, 2'b00};
                STATUS_ADDR: rdata_out <= {start_flag_r, ovf_flag_r, stop_flag_r,
                                           collision, cnt_r};
                DATA_ADDR:   rdata_out <= sr_r;
                default:     rdata_out <= 8'h00;
            endcase
        end
    end

    // Clockless start catcher for wake-up; cleared with the start flag
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_clr_r <= 1'b0;
        end else begin
            wake_clr_r <= start_clr;
        end
    end

    assign wake_rst_n = nrst_in && !wake_clr_r;

    always_ff @(negedge sda_in or negedge wake_rst_n) begin
        if (!wake_rst_n) begin
            wake_r <= 1'b0;
        end else if (scl_in && two_wire) begin
            wake_r <= 1'b1;
        end
    end

    assign wake_out = wake_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    chk_start_set_wins: assert property (start_set |=> start_flag_r)
        else $error("start flag missed a detected start");
    chk_start_clear: assert property (start_clr && !start_set |=> !start_flag_r ##1 !start_hold_r)
        else $error("start flag or hold not released by clear");
    chk_ovf_wrap: assert property (cnt_en && !status_wr && cnt_r == CNT_MAX
                                   |=> ovf_flag_r && cnt_r == CNT_RST)
        else $error("counter wrap did not set overflow");
    chk_data_write_wins: assert property (data_wr |=> sr_r == $past(wdata_in))
        else $error("written data lost to a shift");
    chk_shift_left: assert property (shift_en && !data_wr
                                     |=> sr_r == {$past(sr_r[6:0]), $past(sda_f_r)})
        else $error("shift register did not shift left");
    chk_ext_count: assert property (cs_r[1] && !swc_r && scl_edge && !status_wr
                                    |=> cnt_r == $past(cnt_nxt))
        else $error("external edge not counted");
    chk_ovf_hold_scl: assert property (two_wire && ovf_flag_r |-> scl_oe_out)
        else $error("scl not held after overflow");
    chk_start_hold: assert property (two_wire && start_flag_r && !scl_f_r && !start_clr
                                     |=> ##1 scl_oe_out)
        else $error("scl not held after start");
    chk_sda_pull: assert property (two_wire && dir_sda_in && !out_bit |-> sda_oe_out)
        else $error("sda not pulled low for zero bit");
    chk_stop_flag: assert property (stop_det |=> stop_flag_r)
        else $error("stop condition not flagged");
    chk_collision_read: assert property (rd_in && addr_in == STATUS_ADDR
                                         |=> rdata_out[ST_COLL] == $past(collision))
        else $error("collision bit misreported");

    cov_start_seen: cover property (start_det ##[1:200] start_hold_r);
    cov_byte_done: cover property (two_wire && ovf_set);
    cov_stop_seen: cover property (stop_det);

endmodule : usts_top

// [rtl/usts_pkg.sv]
// Constants and types for the universal serial two-wire shifter
package usts_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] CTRL_ADDR   = 8'hB8;
    localparam logic [7:0] STATUS_ADDR = 8'hB9;
    localparam logic [7:0] DATA_ADDR   = 8'hBA;

    // Status register fields
    localparam int ST_START = 7;
    localparam int ST_OVF   = 6;
    localparam int ST_STOP  = 5;
    localparam int ST_COLL  = 4;

    // Control register fields
    localparam int CT_SIE   = 7;
    localparam int CT_OIE   = 6;
    localparam int CT_WM_LO = 4;
    localparam int CT_CS_LO = 2;
    localparam int CT_CLK   = 1;
    localparam int CT_TC    = 0;

    // Values after reset, and the counter's maximum and step
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic [3:0] CNT_MAX   = 4'hF;
    localparam logic [3:0] CNT_ONE   = 4'h1;

    // Start detector data delay, rounded up to whole clock cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int SDA_DLY_NS    = 50;
    localparam int SDA_DLY_CYC   = (SDA_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        WM_OFF,
        WM_THREE,
        WM_TWO,
        WM_TWO_HOLD
    } usts_wire_mode_t;

    typedef enum logic [1:0] {
        CS_SOFT,
        CS_TIMER,
        CS_EXT_RISE,
        CS_EXT_FALL
    } usts_clk_src_t;

endpackage : usts_pkg

// [dv/usts_bus_master.sv]
// Behavioural two-wire bus master that drives the shifter's SDA and SCL pins
`timescale 1ns/100ps
module usts_bus_master #(
    parameter int HALF_CYC = 8
) (
    input  wire logic clk_in,
    input  wire logic sda_in,
    input  wire logic scl_in,
    output logic      sda_low_out,
    output logic      scl_low_out,
    output logic      sampled_out,
    output logic      stuck_out
);
    initial begin
        sda_low_out = 1'b0;
        scl_low_out = 1'b0;
        sampled_out = 1'b1;
        stuck_out   = 1'b0;
    end

    // Half of a 160 ns link period at the 10 ns system clock
    task automatic half();
        repeat (HALF_CYC) @(posedge clk_in);
    endtask : half

    task automatic set_sda(input logic v);
        @(posedge clk_in);
        sda_low_out <= ~v;
        half();
    endtask : set_sda

    // Releasing SCL waits until the line really is high: a slave may hold it
    task automatic set_scl(input logic v);
        int n;
        @(posedge clk_in);
        scl_low_out <= ~v;
        n = 0;
        while (v && scl_in !== 1'b1 && n < 1000) begin
            @(posedge clk_in);
            n++;
        end
        stuck_out <= (n >= 1000);
        half();
        sampled_out <= sda_in;
    endtask : set_scl

    // Data bit clock pulses are made here, one bit per pulse
    task automatic put_bit(input logic b);
        set_sda(b);
        set_scl(1'b1);
        set_scl(1'b0);
    endtask : put_bit
endmodule : usts_bus_master

// [dv/usts_top_tb.sv]
// Self-checking testbench for the universal serial two-wire shifter
`timescale 1ns/100ps
module usts_top_tb;
    import usts_pkg::*;

    localparam logic [7:0] ADDR_BYTE = 8'hA5;

    logic       clk_in, nrst_in, wr_in, rd_in, timer_match_in, global_irq_en_in;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic       sda_out, sda_oe_out, scl_out, scl_oe_out, do_out, do_oe_out;
    logic       dir_sda_in, start_irq_out, ovf_irq_out, toggle_strobe_out, wake_out;
    logic       port_sda_in, port_scl_in, dir_scl_in, dir_do_in;
    logic       m_sda_low, m_scl_low, m_sampled, m_stuck;
    wire        sda_w = ~(sda_oe_out | m_sda_low);
    wire        scl_w = ~(scl_oe_out | m_scl_low);
    int         n_errors, compares;

    usts_top dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe_out(scl_oe_out), .do_out(do_out), .do_oe_out(do_oe_out),
        .port_sda_in(port_sda_in), .dir_sda_in(dir_sda_in), .port_scl_in(port_scl_in),
        .dir_scl_in(dir_scl_in), .dir_do_in(dir_do_in), .timer_match_in(timer_match_in),
        .global_irq_en_in(global_irq_en_in), .start_irq_out(start_irq_out),
        .ovf_irq_out(ovf_irq_out), .toggle_strobe_out(toggle_strobe_out),
        .wake_out(wake_out)
    );

    usts_bus_master u_m (
        .clk_in(clk_in), .sda_in(sda_w), .scl_in(scl_w), .sda_low_out(m_sda_low),
        .scl_low_out(m_scl_low), .sampled_out(m_sampled), .stuck_out(m_stuck)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd

    task automatic settle();
        @(posedge clk_in);
        #1;
    endtask : settle

    // Polls the status register until one flag is set, under a bounded count
    task automatic wait_flag(input int idx);
        logic [7:0] d;
        int         n;
        d = 8'h00;
        n = 0;
        while (d[idx] !== 1'b1 && n < 40) begin
            rd(STATUS_ADDR, d);
            n++;
        end
        chk({7'h00, d[idx]}, 8'h01);
    endtask : wait_flag

    task automatic t_reset_values();
        logic [7:0] d;
        rd(STATUS_ADDR, d);
        chk(d, 8'h00);
        rd(8'h00, d);
        chk(d, 8'h00);
    endtask : t_reset_values

    task automatic t_soft_strobe();
        logic [7:0] d;
        wr(DATA_ADDR, 8'h81);
        wr(STATUS_ADDR, 8'h0F);
        wr(CTRL_ADDR, 8'h42);
        rd(DATA_ADDR, d);
        chk(d, 8'h03);
        rd(STATUS_ADDR, d);
        chk(d & 8'hEF, 8'h40);
        chk({7'h00, ovf_irq_out}, 8'h01);
        @(posedge clk_in);
        global_irq_en_in <= 1'b0;
        settle();
        chk({7'h00, ovf_irq_out}, 8'h00);
        @(posedge clk_in);
        global_irq_en_in <= 1'b1;
        wr(STATUS_ADDR, 8'h40);
        rd(STATUS_ADDR, d);
        chk(d & 8'hEF, 8'h00);
    endtask : t_soft_strobe

    task automatic t_timer_vs_write();
        logic [7:0] d;
        wr(CTRL_ADDR, 8'h04);
        @(posedge clk_in);
        addr_in        <= DATA_ADDR;
        wdata_in       <= 8'h3C;
        wr_in          <= 1'b1;
        timer_match_in <= 1'b1;
        @(posedge clk_in);
        wr_in          <= 1'b0;
        timer_match_in <= 1'b0;
        rd(DATA_ADDR, d);
        chk(d, 8'h3C);
        @(posedge clk_in);
        timer_match_in <= 1'b1;
        @(posedge clk_in);
        timer_match_in <= 1'b0;
        rd(DATA_ADDR, d);
        chk(d, 8'h79);
    endtask : t_timer_vs_write

    // Three-wire output path, software clocking keeps the latch open
    task automatic t_three_wire();
        wr(DATA_ADDR, 8'h80);
        dir_do_in <= 1'b1;
        wr(CTRL_ADDR, 8'h11);
        #1;
        chk({5'h00, toggle_strobe_out, do_oe_out, do_out}, 8'h07);
        settle();
        chk({7'h00, toggle_strobe_out}, 8'h00);
        wr(DATA_ADDR, 8'h00);
        #1;
        chk({6'h00, do_oe_out, do_out}, 8'h02);
    endtask : t_three_wire

    task automatic t_ext_edges();
        logic [7:0] d;
        wr(CTRL_ADDR, 8'h08);
        wr(STATUS_ADDR, 8'hCF);
        u_m.set_scl(1'b0);
        rd(STATUS_ADDR, d);
        chk(d & 8'hEF, 8'hC0);
        wr(STATUS_ADDR, 8'hC0);
        u_m.set_scl(1'b1);
        rd(STATUS_ADDR, d);
        chk(d & 8'hEF, 8'h81);
    endtask : t_ext_edges

    task automatic t_two_wire();
        logic [7:0] d;
        // Internal clocking opens the latch so the held bit follows bit 7
        wr(CTRL_ADDR, 8'h00);
        wr(DATA_ADDR, 8'hFF);
        wr(STATUS_ADDR, 8'hE0);
        wr(CTRL_ADDR, 8'hA8);
        u_m.set_sda(1'b0);
        wait_flag(ST_START);
        chk({6'h00, start_irq_out, wake_out}, 8'h03);
        u_m.set_scl(1'b0);
        settle();
        chk({7'h00, scl_oe_out}, 8'h01);
        wr(STATUS_ADDR, 8'h80);
        settle();
        chk({7'h00, scl_oe_out}, 8'h00);
        for (int i = 7; i >= 0; i--) begin
            u_m.put_bit(ADDR_BYTE[i]);
        end
        wait_flag(ST_OVF);
        rd(DATA_ADDR, d);
        chk(d, ADDR_BYTE);
        chk({7'h00, scl_oe_out}, 8'h01);
        wr(DATA_ADDR, 8'h00);
        wr(STATUS_ADDR, 8'h4E);
        settle();
        chk({6'h00, sda_oe_out, scl_oe_out}, 8'h02);
        @(posedge clk_in);
        dir_sda_in <= 1'b0;
        settle();
        chk({7'h00, sda_oe_out}, 8'h00);
        @(posedge clk_in);
        dir_sda_in <= 1'b1;
        u_m.put_bit(1'b1);
        chk({6'h00, m_sampled, m_stuck}, 8'h00);
        wait_flag(ST_OVF);
        wr(DATA_ADDR, 8'hFF);
        wr(STATUS_ADDR, 8'h4E);
        u_m.put_bit(1'b1);
        chk({7'h00, m_sampled}, 8'h01);
        wait_flag(ST_OVF);
        wr(STATUS_ADDR, 8'h40);
        u_m.set_sda(1'b0);
        u_m.set_scl(1'b1);
        rd(STATUS_ADDR, d);
        chk({7'h00, d[ST_COLL]}, 8'h01);
        u_m.set_sda(1'b1);
        wait_flag(ST_STOP);
        chk({6'h00, sda_out, scl_out}, 8'h00);
        @(posedge clk_in);
        port_scl_in <= 1'b0;
        settle();
        chk({6'h00, sda_oe_out, scl_oe_out}, 8'h01);
        @(posedge clk_in);
        port_sda_in <= 1'b0;
        settle();
        chk({6'h00, sda_oe_out, scl_oe_out}, 8'h03);
        @(posedge clk_in);
        dir_scl_in <= 1'b0;
        settle();
        chk({6'h00, sda_oe_out, scl_oe_out}, 8'h02);
    endtask : t_two_wire

    initial begin
        n_errors         = 0;
        compares         = 0;
        nrst_in          = 1'b0;
        addr_in          = 8'h00;
        wdata_in         = 8'h00;
        wr_in            = 1'b0;
        rd_in            = 1'b0;
        timer_match_in   = 1'b0;
        global_irq_en_in = 1'b1;
        dir_sda_in       = 1'b1;
        port_sda_in      = 1'b1;
        port_scl_in      = 1'b1;
        dir_scl_in       = 1'b1;
        dir_do_in        = 1'b0;
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset_values();
        t_soft_strobe();
        t_timer_vs_write();
        t_three_wire();
        t_ext_edges();
        t_two_wire();
        test_done();
    end

    // The whole sequence needs well under 10,000 cycles
    initial begin
        #500_000;
        n_errors++;
        test_done();
    end
endmodule : usts_top_tb
